// [rtl/tbp_regs.vh]
// Register map, field positions and reset values of the timer pair
`ifndef TBP_REGS_VH
`define TBP_REGS_VH

// Register byte offsets: each control register has clear, set and invert aliases
`define TBP_EVEN_CTRL       8'h00
`define TBP_EVEN_CTRL_CLR   8'h04
`define TBP_EVEN_CTRL_SET   8'h08
`define TBP_EVEN_CTRL_INV   8'h0C
`define TBP_EVEN_COUNT      8'h10
`define TBP_EVEN_PERIOD     8'h14
`define TBP_ODD_CTRL        8'h20
`define TBP_ODD_CTRL_CLR    8'h24
`define TBP_ODD_CTRL_SET    8'h28
`define TBP_ODD_CTRL_INV    8'h2C
`define TBP_ODD_COUNT       8'h30
`define TBP_ODD_PERIOD      8'h34
`define TBP_IRQ_STATUS      8'h40
`define TBP_IRQ_MASK        8'h44

// Control field positions
`define TBP_BIT_ENABLE      15
`define TBP_BIT_IDLE_STOP   13
`define TBP_BIT_GATE        7
`define TBP_BIT_PS_HI       6
`define TBP_BIT_PS_LO       4
`define TBP_BIT_JOIN        3
`define TBP_BIT_SRC         1

// Writable control bits: even timer has the join bit, odd timer does not
`define TBP_EVEN_CTRL_MASK  32'h0000_A0FA
`define TBP_ODD_CTRL_MASK   32'h0000_A0F2
`define TBP_CTRL_RESET      32'h0000_0000
`define TBP_PERIOD_RESET    16'hFFFF

// Interrupt status bits
`define TBP_IRQ_EVEN        0
`define TBP_IRQ_ODD         1

`endif

// [rtl/tbp_counter.v]
// One 16-bit timer slice: prescaler, gate handling and period counter
`timescale 1ns/10ps
module tbp_counter #(
  parameter WIDTH = 16
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire             run_i,
  input  wire             src_ext_i,
  input  wire             gate_en_i,
  input  wire [2:0]       ps_sel_i,
  input  wire             ext_pin_i,
  input  wire             gate_pin_i,
  input  wire             wr_count_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire [WIDTH-1:0] period_i,
  output reg  [WIDTH-1:0] count_o,
  output reg              wrap_o,
  output reg              gate_fall_o,
  output wire             roll_o
);

  reg  [7:0] prescale;
  reg        ext_prev;
  reg        gate_prev;
  reg  [7:0] ps_limit;
  wire       gated;
  wire       tick_in;
  wire       tick;

  // Prescale code to divide-by minus one
  always @* begin
    case (ps_sel_i)
      3'h0: ps_limit = 8'h00;
      3'h1: ps_limit = 8'h01;
      3'h2: ps_limit = 8'h03;
      3'h3: ps_limit = 8'h07;
      3'h4: ps_limit = 8'h0F;
      3'h5: ps_limit = 8'h1F;
      3'h6: ps_limit = 8'h3F;
      default: ps_limit = 8'hFF;
    endcase
  end

  // Gate only applies to the internal source
  assign gated   = gate_en_i & ~src_ext_i;
  assign tick_in = src_ext_i ? (ext_pin_i & ~ext_prev) : (~gated | gate_pin_i);
  assign tick    = run_i & tick_in & (prescale == ps_limit);
  // Wrap at this edge, seen in time for a joined upper half
  assign roll_o  = tick & ~wr_count_i & (count_o == period_i);

  // Prescaler, edge history and counter
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prescale    <= 8'h00;
      ext_prev    <= 1'b0;
      gate_prev   <= 1'b0;
      count_o     <= {WIDTH{1'b0}};
      wrap_o      <= 1'b0;
      gate_fall_o <= 1'b0;
    end else begin
      ext_prev    <= ext_pin_i;
      gate_prev   <= gate_pin_i;
      wrap_o      <= 1'b0;
      gate_fall_o <= run_i & gated & gate_prev & ~gate_pin_i;
      if (!run_i) begin
        prescale <= 8'h00;
      end else if (tick_in) begin
        prescale <= (prescale == ps_limit) ? 8'h00 : prescale + 8'h01;
      end
      if (wr_count_i) begin
        count_o <= wr_data_i;
      end else if (tick) begin
        if (count_o == period_i) begin
          count_o <= {WIDTH{1'b0}};
          wrap_o  <= ~gated;
        end else begin
          count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// [rtl/tbp_timer_pair.v]
// Pair of 16-bit timers joinable into one 32-bit timer, with APB registers
//
// Contract
// - Each timer counts 16-bit free-running from internal, gated or external source.
// - Even and odd timers may join into one 32-bit counter, same modes.
// - Control bit 15 enables the timer; resets to zero.
// - Control bit 13 set stops the timer in Idle mode.
// - Bit 7 gates internal clock; with external source ignored and reads zero.
// - Bits 6-4 prescale by 1,2,4,8,16,32,64,256.
// - Even timer bit 3 joins the pair into a 32-bit timer.
// - The join bit exists only in the even timer.
// - In joined mode odd timer enable, gate, prescale, source have no effect.
// - Control bit 1 selects external pin when set, internal clock when clear.
// - Only this pair's counters are offered as capture/compare time base.
// - Only the odd timer, or joined pair, drives the converter trigger.
// - Unimplemented control bits read as zero.
// - Clear, set and invert aliases modify control bits atomically.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_timer_pair (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        idle_mode_i,
  input  wire        even_count_pin_i,
  input  wire        even_gate_pin_i,
  input  wire        odd_count_pin_i,
  input  wire        odd_gate_pin_i,
  output reg  [31:0] time_base_o,
  output reg         joined_o,
  output reg         adc_trigger_o,
  output reg         irq_o
);

  // ==========================================================
  // Register storage
  reg  [31:0] even_ctrl;
  reg  [31:0] odd_ctrl;
  reg  [15:0] even_period;
  reg  [15:0] odd_period;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  reg  [31:0] next_even_ctrl;
  reg  [31:0] next_odd_ctrl;
  reg  [31:0] rd_data;
  reg         rd_ok;

  wire        access;
  wire        wr;
  wire        pair_join;
  wire [15:0] even_count;
  wire [15:0] odd_count;
  wire        even_wrap;
  wire        odd_wrap;
  wire        even_gfall;
  wire        odd_gfall;
  wire        even_roll;
  wire        odd_top;
  wire        odd_load;
  wire [15:0] odd_load_val;
  wire        even_gated;
  wire        wrap32;
  wire        even_run;
  wire        odd_run;
  wire        lo_run;
  wire [1:0]  irq_set;

  assign access    = psel_i & penable_i & pready_o;
  assign wr        = access & pwrite_i;
  assign pair_join = even_ctrl[`TBP_BIT_JOIN];

  // ==========================================================
  // Timer enables
  assign even_run = even_ctrl[`TBP_BIT_ENABLE] &
                    ~(idle_mode_i & even_ctrl[`TBP_BIT_IDLE_STOP]);
  // Joined: odd half runs from even enable, yet obeys its own idle stop
  assign odd_run  = pair_join ? (even_run & ~(idle_mode_i & odd_ctrl[`TBP_BIT_IDLE_STOP]))
                              : (odd_ctrl[`TBP_BIT_ENABLE] &
                                 ~(idle_mode_i & odd_ctrl[`TBP_BIT_IDLE_STOP]));
  assign lo_run   = pair_join ? (even_run & odd_run) : even_run;

  // Joined: once the upper half sits at its period, the lower half wraps at its own
  assign odd_top  = (odd_count == odd_period);

  tbp_counter #(.WIDTH(16)) u_even (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .run_i       (lo_run),
    .src_ext_i   (even_ctrl[`TBP_BIT_SRC]),
    .gate_en_i   (even_ctrl[`TBP_BIT_GATE]),
    .ps_sel_i    (even_ctrl[`TBP_BIT_PS_HI:`TBP_BIT_PS_LO]),
    .ext_pin_i   (even_count_pin_i),
    .gate_pin_i  (even_gate_pin_i),
    .wr_count_i  (wr & (paddr_i == `TBP_EVEN_COUNT)),
    .wr_data_i   (pwdata_i[15:0]),
    .period_i    (pair_join ? (odd_top ? even_period : 16'hFFFF) : even_period),
    .count_o     (even_count),
    .wrap_o      (even_wrap),
    .gate_fall_o (even_gfall),
    .roll_o      (even_roll)
  );

  // Joined: upper half steps, or clears at the 32-bit period, at the same edge as the lower roll
  assign odd_load     = (wr & (paddr_i == `TBP_ODD_COUNT)) | (pair_join & even_roll);
  assign odd_load_val = (wr & (paddr_i == `TBP_ODD_COUNT)) ? pwdata_i[15:0] :
                        (odd_top ? 16'h0000 : odd_count + 16'h0001);

  tbp_counter #(.WIDTH(16)) u_odd (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .run_i       (pair_join ? 1'b0 : odd_run),
    .src_ext_i   (odd_ctrl[`TBP_BIT_SRC]),
    .gate_en_i   (odd_ctrl[`TBP_BIT_GATE]),
    .ps_sel_i    (odd_ctrl[`TBP_BIT_PS_HI:`TBP_BIT_PS_LO]),
    .ext_pin_i   (odd_count_pin_i),
    .gate_pin_i  (odd_gate_pin_i),
    .wr_count_i  (odd_load),
    .wr_data_i   (odd_load_val),
    .period_i    (odd_period),
    .count_o     (odd_count),
    .wrap_o      (odd_wrap),
    .gate_fall_o (odd_gfall),
    .roll_o      ()
  );

  // Joined wrap; in gated mode only the gate's falling edge flags
  assign even_gated = even_ctrl[`TBP_BIT_GATE] & ~even_ctrl[`TBP_BIT_SRC];
  assign wrap32     = pair_join & even_roll & odd_top & ~even_gated;

  // Interrupt events; joined events land on the odd flag
  assign irq_set[`TBP_IRQ_EVEN] = ~pair_join & (even_wrap | even_gfall);
  assign irq_set[`TBP_IRQ_ODD]  = pair_join ? (wrap32 | even_gfall) : (odd_wrap | odd_gfall);

  // ==========================================================
  // Control write with aliases
  always @* begin
    next_even_ctrl = even_ctrl;
    next_odd_ctrl  = odd_ctrl;
    if (wr) begin
      case (paddr_i)
        `TBP_EVEN_CTRL:     next_even_ctrl = pwdata_i;
        `TBP_EVEN_CTRL_CLR: next_even_ctrl = even_ctrl & ~pwdata_i;
        `TBP_EVEN_CTRL_SET: next_even_ctrl = even_ctrl | pwdata_i;
        `TBP_EVEN_CTRL_INV: next_even_ctrl = even_ctrl ^ pwdata_i;
        `TBP_ODD_CTRL:      next_odd_ctrl  = pwdata_i;
        `TBP_ODD_CTRL_CLR:  next_odd_ctrl  = odd_ctrl & ~pwdata_i;
        `TBP_ODD_CTRL_SET:  next_odd_ctrl  = odd_ctrl | pwdata_i;
        `TBP_ODD_CTRL_INV:  next_odd_ctrl  = odd_ctrl ^ pwdata_i;
        default: begin
          next_even_ctrl = even_ctrl;
        end
      endcase
    end
    next_even_ctrl = next_even_ctrl & `TBP_EVEN_CTRL_MASK;
    next_odd_ctrl  = next_odd_ctrl & `TBP_ODD_CTRL_MASK;
  end

  // Read view of control: gate bit reads zero with external source
  function [31:0] tbp_ctrl_view;
    input [31:0] ctrl;
    begin
      tbp_ctrl_view = ctrl;
      if (ctrl[`TBP_BIT_SRC]) begin
        tbp_ctrl_view[`TBP_BIT_GATE] = 1'b0;
      end
    end
  endfunction

  // Read decode
  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr_i)
      `TBP_EVEN_CTRL:   rd_data = tbp_ctrl_view(even_ctrl);
      `TBP_ODD_CTRL:    rd_data = tbp_ctrl_view(odd_ctrl);
      `TBP_EVEN_COUNT:  rd_data = {16'h0000, even_count};
      `TBP_ODD_COUNT:   rd_data = {16'h0000, odd_count};
      `TBP_EVEN_PERIOD: rd_data = {16'h0000, even_period};
      `TBP_ODD_PERIOD:  rd_data = {16'h0000, odd_period};
      `TBP_IRQ_STATUS:  rd_data = {30'h0000_0000, irq_status};
      `TBP_IRQ_MASK:    rd_data = {30'h0000_0000, irq_mask};
      `TBP_EVEN_CTRL_CLR, `TBP_EVEN_CTRL_SET, `TBP_EVEN_CTRL_INV,
      `TBP_ODD_CTRL_CLR, `TBP_ODD_CTRL_SET, `TBP_ODD_CTRL_INV: rd_data = 32'h0000_0000;
      default:          rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // Registers, APB answer and outputs
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      even_ctrl     <= `TBP_CTRL_RESET;
      odd_ctrl      <= `TBP_CTRL_RESET;
      even_period   <= `TBP_PERIOD_RESET;
      odd_period    <= `TBP_PERIOD_RESET;
      irq_status    <= 2'h0;
      irq_mask      <= 2'h0;
      prdata_o      <= 32'h0000_0000;
      pready_o      <= 1'b0;
      pslverr_o     <= 1'b0;
      time_base_o   <= 32'h0000_0000;
      joined_o      <= 1'b0;
      adc_trigger_o <= 1'b0;
      irq_o         <= 1'b0;
    end else begin
      even_ctrl <= next_even_ctrl;
      odd_ctrl  <= next_odd_ctrl;
      if (wr && paddr_i == `TBP_EVEN_PERIOD) begin
        even_period <= pwdata_i[15:0];
      end
      if (wr && paddr_i == `TBP_ODD_PERIOD) begin
        odd_period <= pwdata_i[15:0];
      end
      if (wr && paddr_i == `TBP_IRQ_MASK) begin
        irq_mask <= pwdata_i[1:0];
      end
      // Set beats write-one-to-clear
      if (wr && paddr_i == `TBP_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata_i[1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      // No wait cycle, answer in first access cycle
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~rd_ok;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_data : 32'h0000_0000;
      time_base_o   <= {odd_count, even_count};
      joined_o      <= pair_join;
      adc_trigger_o <= pair_join ? wrap32 : odd_wrap;
      irq_o         <= |((irq_status | irq_set) & irq_mask);
    end
  end

endmodule

// [test/tbp_pair_props.sv]
// Checker of bus answers, refusals, join level and reset state at the pair's ports
`timescale 1ns/10ps
`include "tbp_regs.vh"
module tbp_pair_props (
  input logic        clk_i,
  input logic        nrst_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [7:0]  paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic [31:0] time_base_o,
  input logic        joined_o,
  input logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Bus phases and a direct write of the even control word
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence ctrl_wr_s; pready_o && pwrite_i && paddr_i == `TBP_EVEN_CTRL; endsequence
  setup_ready_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  err_map_a: assert property (pready_o |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C,
    8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h40, 8'h44})) else $error("wrong refusal");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  join_set_a: assert property (ctrl_wr_s ##0 pwdata_i[3] |-> ##[1:2] joined_o)
    else $error("join not taken");
  join_clr_a: assert property (ctrl_wr_s ##0 !pwdata_i[3] |-> ##[1:2] !joined_o)
    else $error("join not dropped");
  reset_quiet_a: assert property ($rose(nrst_i) |-> time_base_o == 32'h0 && !joined_o && !irq_o)
    else $error("outputs not clear after reset");
endmodule

// [test/tbp_pin_model.sv]
// External count and gate pin source for the timer pair
`timescale 1ns/10ps
module tbp_pin_model (
  input  logic       clk_i,
  input  logic       go_i,
  input  logic [7:0] n_i,
  input  logic       gate_i,
  output logic       count_pin_o,
  output logic       gate_pin_o,
  output logic       done_o
);
  logic [7:0] left;
  logic [1:0] ph;
  // Emits n_i rising edges, two clocks high, two low, then rests low
  always @(posedge clk_i) begin
    gate_pin_o <= gate_i;
    if (!go_i) begin
      left <= n_i;
      ph <= 2'h0;
      count_pin_o <= 1'b0;
    end else if (left != 8'h00) begin
      ph <= ph + 2'h1;
      if (ph == 2'h1) count_pin_o <= 1'b1;
      if (ph == 2'h3) begin
        count_pin_o <= 1'b0;
        left <= left - 8'h01;
      end
    end
  end
  assign done_o = go_i && (left == 8'h00);
endmodule

// [test/testbench.sv]
// Self-checking bench of the timer pair
`timescale 1ns/10ps
`include "tbp_regs.vh"
module testbench;
  logic        clk_i, nrst_i, psel, penable, pwrite, idle, go, gate, e;
  logic        pready_o, pslverr_o, joined_o, adc_trigger_o, irq_o, cpin, gpin, done;
  logic [7:0]  paddr, n;
  logic [31:0] pwdata, prdata_o, time_base_o, r, v;
  int          fails, n_checks, g, c;
  tbp_timer_pair u_tbp_timer_pair (.clk_i, .nrst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o, .pslverr_o, .idle_mode_i(idle),
    .even_count_pin_i(cpin), .even_gate_pin_i(gpin), .odd_count_pin_i(cpin), .odd_gate_pin_i(gpin),
    .time_base_o, .joined_o, .adc_trigger_o, .irq_o);
  tbp_pin_model u_tbp_pin_model (.clk_i, .go_i(go), .n_i(n), .gate_i(gate), .count_pin_o(cpin),
    .gate_pin_o(gpin), .done_o(done));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    n_checks++;
    if (seen !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, x, seen);
    end
  endtask
  // One bus transfer; idle cycle after it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdv, output logic er);
    int k;
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    // Ready and read data taken at the rising edge, before the design updates them
    do begin @(posedge clk_i); k++; end while (pready_o !== 1'b1 && k < 20);
    rdv = prdata_o;
    er = pslverr_o;
    psel <= 1'b0; penable <= 1'b0;
    if (pready_o !== 1'b1) begin fails++; conclude; end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, r, e); endtask
  task rd(input logic [7:0] a, input logic [31:0] x); apb(1'b0, a, 32'h0, r, e); chk($sformatf("reg %h", a), r, x); endtask
  // Cycles between two trigger pulses
  task adc_gap(output int gp);
    int k;
    k = 0;
    do begin @(negedge clk_i); k++; end while (adc_trigger_o !== 1'b1 && k < 70000);
    gp = 0;
    do begin @(negedge clk_i); gp++; end while (adc_trigger_o !== 1'b1 && gp < 70000);
    if (gp >= 70000) begin fails++; conclude; end
  endtask
  task cnt(input int m, output int cn);
    cn = 0;
    repeat (m) begin @(negedge clk_i); if (adc_trigger_o === 1'b1) cn++; end
  endtask
  task t_reset;
    @(negedge clk_i);
    chk("time base", time_base_o, 32'h0);
    rd(`TBP_EVEN_CTRL, `TBP_CTRL_RESET);
    rd(`TBP_ODD_CTRL, `TBP_CTRL_RESET);
    rd(`TBP_EVEN_PERIOD, 32'h0000_FFFF);
    $display("reset test done");
  endtask
  task t_fields;
    wr(`TBP_EVEN_CTRL, 32'hFFFF_FFFF);
    rd(`TBP_EVEN_CTRL, 32'h0000_A07A);
    wr(`TBP_ODD_CTRL, 32'hFFFF_FFFF);
    rd(`TBP_ODD_CTRL, 32'h0000_A072);
    wr(`TBP_EVEN_CTRL, 32'h0000_0080);
    rd(`TBP_EVEN_CTRL, 32'h0000_0080);
    wr(`TBP_EVEN_CTRL_SET, 32'h0000_0030);
    rd(`TBP_EVEN_CTRL, 32'h0000_00B0);
    wr(`TBP_EVEN_CTRL_CLR, 32'h0000_0090);
    rd(`TBP_EVEN_CTRL, 32'h0000_0020);
    wr(`TBP_EVEN_CTRL_INV, 32'h0000_0060);
    rd(`TBP_EVEN_CTRL, 32'h0000_0040);
    rd(`TBP_EVEN_CTRL_CLR, 32'h0);
    apb(1'b1, 8'h3C, 32'h1, r, e);
    chk("unmapped error", e, 32'h1);
    wr(`TBP_EVEN_CTRL, 32'h0);
    wr(`TBP_ODD_CTRL, 32'h0);
    $display("field test done");
  endtask
  task t_prescale;
    wr(`TBP_ODD_PERIOD, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(`TBP_ODD_CTRL, 32'h8000 | (k << 4));
      adc_gap(g);
      adc_gap(g);
      chk($sformatf("gap code %0d", k), g, (k == 7 ? 256 : 1 << k) * 2);
    end
    wr(`TBP_ODD_CTRL, 32'h0);
    $display("prescale test done");
  endtask
  task t_idle;
    @(posedge clk_i) idle <= 1'b1;
    wr(`TBP_ODD_CTRL, 32'h0000_A000);
    cnt(40, c);
    chk("idle stopped", c, 32'h0);
    wr(`TBP_ODD_CTRL_CLR, 32'h0000_2000);
    repeat (4) @(negedge clk_i);
    cnt(40, c);
    chk("idle running", c, 32'd20);
    @(posedge clk_i) idle <= 1'b0;
    wr(`TBP_ODD_CTRL, 32'h0);
    $display("idle test done");
  endtask
  task t_pins;
    wr(`TBP_EVEN_COUNT, 32'h0);
    wr(`TBP_ODD_COUNT, 32'h0);
    wr(`TBP_ODD_CTRL, 32'h0000_8002);
    wr(`TBP_EVEN_CTRL, 32'h0000_8002);
    @(posedge clk_i) go <= 1'b1;
    c = 0;
    while (done !== 1'b1 && c < 100) begin @(negedge clk_i); c++; end
    if (c >= 100) begin fails++; conclude; end
    repeat (6) @(posedge clk_i);
    rd(`TBP_EVEN_COUNT, 32'h5);
    rd(`TBP_ODD_COUNT, 32'h1);
    chk("time base pins", time_base_o, 32'h0001_0005);
    go <= 1'b0;
    wr(`TBP_EVEN_COUNT, 32'h0);
    wr(`TBP_ODD_CTRL, 32'h0);
    wr(`TBP_IRQ_STATUS, 32'h3);
    wr(`TBP_EVEN_CTRL, 32'h0000_8080);
    @(posedge clk_i) gate <= 1'b1;
    repeat (10) @(posedge clk_i);
    gate <= 1'b0;
    repeat (5) @(posedge clk_i);
    apb(1'b0, `TBP_EVEN_COUNT, 32'h0, v, e);
    chk("gated count", v, 32'h0000_000A);
    repeat (10) @(posedge clk_i);
    rd(`TBP_EVEN_COUNT, v);
    rd(`TBP_IRQ_STATUS, 32'h1);
    wr(`TBP_EVEN_CTRL, 32'h0);
    $display("pin test done");
  endtask
  task t_join;
    wr(`TBP_ODD_CTRL, 32'h0000_0070);
    wr(`TBP_EVEN_PERIOD, 32'h0);
    wr(`TBP_ODD_PERIOD, 32'h1);
    wr(`TBP_EVEN_COUNT, 32'h0000_FFFE);
    wr(`TBP_ODD_COUNT, 32'h0);
    wr(`TBP_IRQ_STATUS, 32'h3);
    wr(`TBP_EVEN_CTRL, 32'h0000_8008);
    adc_gap(g);
    chk("joined gap", g, 32'h0001_0001);
    chk("joined level", joined_o, 32'h1);
    rd(`TBP_IRQ_STATUS, 32'h2);
    chk("irq masked", irq_o, 32'h0);
    wr(`TBP_IRQ_MASK, 32'h2);
    repeat (3) @(negedge clk_i);
    chk("irq raised", irq_o, 32'h1);
    wr(`TBP_EVEN_CTRL, 32'h0);
    wr(`TBP_IRQ_STATUS, 32'h2);
    repeat (3) @(negedge clk_i);
    chk("irq cleared", irq_o, 32'h0);
    rd(`TBP_IRQ_MASK, 32'h2);
    $display("join test done");
  endtask
  // Main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    idle = 1'b0; go = 1'b0; gate = 1'b0; n = 8'h05; fails = 0; n_checks = 0; nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset; t_fields; t_prescale; t_idle; t_pins; t_join;
    conclude;
  end
endmodule
bind tbp_timer_pair tbp_pair_props u_tbp_pair_props (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .time_base_o, .joined_o, .irq_o);
